// ---- inc/uaf_pkg.sv ----
// uaf_pkg: constants, types and register layout for the serial transceiver.
// assumes a single 200 MHz clock domain and a plain strobed register port.
package uaf_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;
   // register word offsets
   localparam logic [2:0] ADDR_MODE = 3'h0;
   localparam logic [2:0] ADDR_STAT = 3'h1;
   localparam logic [2:0] ADDR_TXD = 3'h2;
   localparam logic [2:0] ADDR_RXD = 3'h3;
   localparam logic [2:0] ADDR_BRG = 3'h4;
   // mode_register fields
   localparam int MODE_EN = 15;
   localparam int MODE_PD_HI = 2;
   localparam int MODE_PD_LO = 1;
   localparam int MODE_STOP = 0;
   // status_register fields
   localparam int ST_TXISEL = 15;
   localparam int ST_BRK = 11;
   localparam int ST_TXEN = 10;
   localparam int ST_TXBF = 9;
   localparam int ST_TX_SHIFT_EMPTY = 8;
   localparam int ST_RXISEL_HI = 7;
   localparam int ST_RXISEL_LO = 6;
   localparam int ST_ADDRESS_DETECT_ENABLE = 5;
   localparam int ST_RX_IDLE_FLAG = 4;
   localparam int ST_PARITY_ERROR = 3;
   localparam int ST_FRAMING_ERROR = 2;
   localparam int ST_RX_OVERRUN = 1;
   localparam int ST_RXDA = 0;
   // reset values
   localparam logic [15:0] BRG_RST = 16'h0000;
   // fifo geometry
   localparam logic [2:0] FIFO_FULL = 3'h4;
   localparam logic [2:0] FIFO_THREE = 3'h3;
   localparam logic [2:0] FIFO_ONE = 3'h1;
   // oversampling: sixteen ticks per bit
   localparam logic [3:0] OVS_LAST = 4'hf;
   localparam logic [3:0] OVS_MID = 4'h7;
   // frame lengths in bits: start + 8 data + 1 stop
   localparam logic [3:0] FRAME_BASE = 4'ha;
   localparam logic [3:0] NBITS_8 = 4'h8;

   typedef enum logic [1:0] {
      PD_8N = 2'b00,
      PD_8E = 2'b01,
      PD_8O = 2'b10,
      PD_9N = 2'b11
   } uaf_data_parity_select_e;

   typedef enum logic [1:0] {
      RXI_ANY0 = 2'b00,
      RXI_ANY1 = 2'b01,
      RXI_THREE = 2'b10,
      RXI_FULL = 2'b11
   } uaf_rxisel_e;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } uaf_rx_e;

   typedef struct packed {
      logic parity_error;
      logic framing_error;
      logic [8:0] data;
   } uaf_rxw_s;

   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } uaf_bus_s;
endpackage

// ---- logic/uaf_uart.sv ----
// uaf_uart: full-duplex async serial transceiver with 4-word fifos each way.
// assumes the register master keeps one-cycle strobes, never both at once,
// and that serial_in comes from outside and must be synchronised.
// How it works
// - enabled module drives line, idles high
// - reset leaves disabled; disable empties fifos, counter
// - disable clears flags, sets idle flags, keeps config
// - disable aborts traffic; re-enable keeps configuration
// - frame 8 bits with parity, or 9
// - reset format is 8N1
// - enable bit 15, transmit enable bit 10
// - written byte loads shifter, starts next clock
// - tx enable late starts stream from clear
// - tx fifo 9x4, full flag bit 9
// - write to full tx fifo dropped
// - device reset empties both fifos
// - tx event per move, or when emptied
// - break forces line low always
// - break never raises tx event
// - rx read pops, updates error flags
// - rx fifo four words, available bit 0
// - empty rx read returns stale, no pop
// - rx event on every, three, or full
// - bit rate clock over sixteen(divisor+1)
// - zero stop sample sets framing error
// - rx idle low during a frame
`timescale 1ns/1ps
module uaf_uart
   import uaf_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // register port
   input wire uaf_bus_s bus_in,
   output logic [DATA_W-1:0] rdata_out,
   // serial line
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe_out,
   // event edges
   output logic tx_irq_out,
   output logic rx_irq_out
);

   function automatic logic par_even(input logic [7:0] d);
      return ^d;
   endfunction

   // configuration and control
   logic module_enable;
   uaf_data_parity_select_e data_parity_select;
   logic stop_bits_select;
   logic [15:0] baud_divisor;
   logic tx_irq_select;
   uaf_rxisel_e rx_irq_select;
   logic address_detect_enable;
   logic transmit_enable;
   logic send_break;
   logic rx_overrun;
   logic alive;

   logic wr_mode, wr_stat, wr_txd, wr_brg, rd_rxd;
   assign wr_mode = bus_in.wr && bus_in.addr == ADDR_MODE;
   assign wr_stat = bus_in.wr && bus_in.addr == ADDR_STAT;
   assign wr_txd = bus_in.wr && bus_in.addr == ADDR_TXD;
   assign wr_brg = bus_in.wr && bus_in.addr == ADDR_BRG;
   assign rd_rxd = bus_in.rd && bus_in.addr == ADDR_RXD;
   // datapath state is held clear by reset or disable
   assign alive = rst_n_in && module_enable;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         module_enable <= 1'b0;
         data_parity_select <= PD_8N;
         stop_bits_select <= 1'b0;
         baud_divisor <= BRG_RST;
      end else begin
         if (wr_mode) begin
            module_enable <= bus_in.wdata[MODE_EN];
            data_parity_select <= uaf_data_parity_select_e'(bus_in.wdata[MODE_PD_HI:MODE_PD_LO]);
            stop_bits_select <= bus_in.wdata[MODE_STOP];
         end
         if (wr_brg) begin
            baud_divisor <= bus_in.wdata;
         end
      end
   end

   // interrupt selects survive disable
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tx_irq_select <= 1'b0;
         rx_irq_select <= RXI_ANY0;
         address_detect_enable <= 1'b0;
      end else if (wr_stat) begin
         tx_irq_select <= bus_in.wdata[ST_TXISEL];
         rx_irq_select <= uaf_rxisel_e'(bus_in.wdata[ST_RXISEL_HI:ST_RXISEL_LO]);
         address_detect_enable <= bus_in.wdata[ST_ADDRESS_DETECT_ENABLE];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!alive) begin
         transmit_enable <= 1'b0;
         send_break <= 1'b0;
      end else if (wr_stat) begin
         transmit_enable <= bus_in.wdata[ST_TXEN];
         send_break <= bus_in.wdata[ST_BRK];
      end
   end

   // baud tick: one pulse per 1/16 bit
   logic [15:0] brg_cnt;
   logic tick16;
   assign tick16 = brg_cnt == baud_divisor;
   always_ff @(posedge clk_in) begin
      if (!alive || tick16) begin
         brg_cnt <= 16'h0000;
      end else begin
         brg_cnt <= brg_cnt + 16'h0001;
      end
   end

   // transmit fifo
   logic [8:0] tx_fifo [4];
   logic [1:0] tx_wp, tx_rp;
   logic [2:0] tx_cnt, next_tx_cnt;
   logic tx_push, tx_load, tx_busy;
   logic [11:0] tx_frame;
   logic [3:0] tx_left, tx_sub;
   logic [8:0] tx_head;

   assign tx_head = tx_fifo[tx_rp];
   assign tx_busy = tx_left != 4'h0;
   assign tx_push = alive && wr_txd && tx_cnt != FIFO_FULL;
   // break holds off loads so a break character never raises a tx event
   assign tx_load = alive && transmit_enable && !send_break && !tx_busy
      && tx_cnt != 3'h0;
   assign next_tx_cnt = tx_cnt + {2'b00, tx_push} - {2'b00, tx_load};

   always_ff @(posedge clk_in) begin
      if (!alive) begin
         tx_wp <= 2'b00;
         tx_rp <= 2'b00;
         tx_cnt <= 3'h0;
      end else begin
         if (tx_push) begin
            tx_wp <= tx_wp + 2'b01;
         end
         if (tx_load) begin
            tx_rp <= tx_rp + 2'b01;
         end
         tx_cnt <= next_tx_cnt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (tx_push) begin
         tx_fifo[tx_wp] <= bus_in.wdata[8:0];
      end
   end

   // transmit shifter; idle shifter keeps sub-count clear so a late enable starts at once
   always_ff @(posedge clk_in) begin
      if (!alive) begin
         tx_left <= 4'h0;
         tx_sub <= 4'h0;
         tx_frame <= '1;
      end else if (tx_load) begin
         tx_sub <= 4'h0;
         tx_left <= FRAME_BASE + {3'b000, data_parity_select != PD_8N}
            + {3'b000, stop_bits_select};
         unique case (data_parity_select)
            PD_8N: tx_frame <= {3'b111, tx_head[7:0], 1'b0};
            PD_8E: tx_frame <= {2'b11, par_even(tx_head[7:0]), tx_head[7:0], 1'b0};
            PD_8O: tx_frame <= {2'b11, ~par_even(tx_head[7:0]), tx_head[7:0], 1'b0};
            PD_9N: tx_frame <= {2'b11, tx_head, 1'b0};
         endcase
      end else if (tx_busy && tick16) begin
         tx_sub <= tx_sub + 4'h1;
         if (tx_sub == OVS_LAST) begin
            tx_frame <= {1'b1, tx_frame[11:1]};
            tx_left <= tx_left - 4'h1;
         end
      end
   end

   always_comb begin
      if (!module_enable) begin
         serial_out = 1'b1;
      end else if (send_break) begin
         serial_out = 1'b0;
      end else begin
         serial_out = tx_busy ? tx_frame[0] : 1'b1;
      end
   end
   assign serial_out_oe_out = module_enable;

   always_ff @(posedge clk_in) begin
      if (!alive) begin
         tx_irq_out <= 1'b0;
      end else begin
         tx_irq_out <= tx_load && (!tx_irq_select || next_tx_cnt == 3'h0);
      end
   end

   // receiver
   logic rx_meta, rx_line, rx_prev;
   uaf_rx_e rx_state;
   logic [3:0] rx_sub, rx_bits, rx_nbits;
   logic [8:0] rx_shift;
   logic rx_framing_error, rx_stop2, rx_end, rx_push;
   uaf_rxw_s rx_word;
   uaf_rxw_s rx_fifo [4];
   logic [1:0] rx_wp, rx_rp;
   logic [2:0] rx_cnt, next_rx_cnt;
   logic rx_pop;
   uaf_rxw_s rx_head;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rx_meta <= 1'b1;
         rx_line <= 1'b1;
      end else begin
         rx_meta <= serial_in;
         rx_line <= rx_meta;
      end
   end

   assign rx_nbits = NBITS_8 + {3'b000, data_parity_select != PD_8N};
   assign rx_end = rx_state == RX_STOP && tick16 && rx_sub == OVS_LAST
      && (rx_stop2 || !stop_bits_select);
   assign rx_push = rx_end && rx_cnt != FIFO_FULL;
   assign rx_pop = rd_rxd && rx_cnt != 3'h0;
   assign next_rx_cnt = rx_cnt + {2'b00, rx_push} - {2'b00, rx_pop};
   assign rx_head = rx_fifo[rx_rp];

   always_comb begin
      rx_word.framing_error = rx_framing_error || !rx_line;
      unique case (data_parity_select)
         PD_8N: begin
            rx_word.data = {1'b0, rx_shift[8:1]};
            rx_word.parity_error = 1'b0;
         end
         PD_8E: begin
            rx_word.data = {1'b0, rx_shift[7:0]};
            rx_word.parity_error = par_even(rx_shift[7:0]) != rx_shift[8];
         end
         PD_8O: begin
            rx_word.data = {1'b0, rx_shift[7:0]};
            rx_word.parity_error = par_even(rx_shift[7:0]) == rx_shift[8];
         end
         PD_9N: begin
            rx_word.data = rx_shift;
            rx_word.parity_error = 1'b0;
         end
      endcase
   end

   // samples taken at mid-bit on the 16x tick
   always_ff @(posedge clk_in) begin
      if (!alive) begin
         rx_state <= RX_IDLE;
         rx_sub <= 4'h0;
         rx_bits <= 4'h0;
         rx_shift <= 9'h000;
         rx_framing_error <= 1'b0;
         rx_stop2 <= 1'b0;
         rx_prev <= 1'b1;
      end else if (tick16) begin
         rx_prev <= rx_line;
         rx_sub <= rx_sub + 4'h1;
         unique case (rx_state)
            RX_IDLE: begin
               rx_sub <= 4'h0;
               // edge needed, so a held break line is not a new start
               if (rx_prev && !rx_line && !rx_overrun) begin
                  rx_state <= RX_START;
               end
            end
            RX_START: begin
               if (rx_sub == OVS_MID) begin
                  rx_sub <= 4'h0;
                  rx_bits <= 4'h0;
                  rx_state <= rx_line ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_sub == OVS_LAST) begin
                  rx_shift <= {rx_line, rx_shift[8:1]};
                  rx_bits <= rx_bits + 4'h1;
                  if (rx_bits + 4'h1 == rx_nbits) begin
                     rx_state <= RX_STOP;
                     rx_framing_error <= 1'b0;
                     rx_stop2 <= 1'b0;
                  end
               end
            end
            RX_STOP: begin
               if (rx_sub == OVS_LAST) begin
                  rx_framing_error <= rx_word.framing_error;
                  rx_stop2 <= 1'b1;
                  if (rx_end) begin
                     rx_state <= RX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!alive) begin
         rx_wp <= 2'b00;
         rx_rp <= 2'b00;
         rx_cnt <= 3'h0;
      end else begin
         if (rx_push) begin
            rx_wp <= rx_wp + 2'b01;
         end
         if (rx_pop) begin
            rx_rp <= rx_rp + 2'b01;
         end
         rx_cnt <= next_rx_cnt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rx_push) begin
         rx_fifo[rx_wp] <= rx_word;
      end
   end

   // overrun: a new frame set beats a software clear in the same cycle
   always_ff @(posedge clk_in) begin
      if (!alive) begin
         rx_overrun <= 1'b0;
      end else if (rx_end && rx_cnt == FIFO_FULL) begin
         rx_overrun <= 1'b1;
      end else if (wr_stat && !bus_in.wdata[ST_RX_OVERRUN]) begin
         rx_overrun <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!alive) begin
         rx_irq_out <= 1'b0;
      end else begin
         unique case (rx_irq_select)
            RXI_ANY0, RXI_ANY1: rx_irq_out <= rx_push;
            RXI_THREE: rx_irq_out <= rx_push && next_rx_cnt == FIFO_THREE;
            RXI_FULL: rx_irq_out <= rx_push && next_rx_cnt == FIFO_FULL;
         endcase
      end
   end

   // read data, one cycle after the strobe
   logic [15:0] stat_word;
   always_comb begin
      stat_word = 16'h0000;
      stat_word[ST_TXISEL] = tx_irq_select;
      stat_word[ST_BRK] = send_break;
      stat_word[ST_TXEN] = transmit_enable;
      stat_word[ST_TXBF] = tx_cnt == FIFO_FULL;
      stat_word[ST_TX_SHIFT_EMPTY] = !tx_busy;
      stat_word[ST_RXISEL_HI:ST_RXISEL_LO] = rx_irq_select;
      stat_word[ST_ADDRESS_DETECT_ENABLE] = address_detect_enable;
      stat_word[ST_RX_IDLE_FLAG] = rx_state == RX_IDLE;
      stat_word[ST_PARITY_ERROR] = rx_cnt != 3'h0 && rx_head.parity_error;
      stat_word[ST_FRAMING_ERROR] = rx_cnt != 3'h0 && rx_head.framing_error;
      stat_word[ST_RX_OVERRUN] = rx_overrun;
      stat_word[ST_RXDA] = rx_cnt != 3'h0;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_out <= 16'h0000;
      end else if (bus_in.rd) begin
         unique case (bus_in.addr)
            ADDR_MODE: rdata_out <= {module_enable, 12'h000, data_parity_select,
               stop_bits_select};
            ADDR_STAT: rdata_out <= stat_word;
            ADDR_RXD: rdata_out <= {7'h00, rx_head.data};
            ADDR_BRG: rdata_out <= baud_divisor;
            default: rdata_out <= 16'h0000;
         endcase
      end else begin
         rdata_out <= 16'h0000;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_load;
      tx_load && !send_break;
   endsequence
   sequence s_start_bit;
      ##1 (serial_out == 1'b0 || send_break);
   endsequence

   a_idle_line_high: assert property (
      module_enable && !tx_busy && !send_break |-> serial_out == 1'b1)
      else $error("line not high while idle");
   a_start_drives_low: assert property (s_load |-> s_start_bit)
      else $error("start bit not driven after load");
   // the clear lands one edge after the enable bit drops
   a_disable_clears: assert property (
      $fell(module_enable) |=> tx_cnt == 3'h0 && rx_cnt == 3'h0 && !transmit_enable)
      else $error("disable left state behind");
   a_break_forces_low: assert property (
      module_enable && send_break |-> serial_out == 1'b0)
      else $error("break not low");
   a_full_write_drop: assert property (
      wr_txd && tx_cnt == FIFO_FULL && !tx_load |=> tx_cnt == FIFO_FULL && $stable(tx_wp))
      else $error("write to full tx fifo accepted");
   a_load_needs_enable: assert property (
      $rose(tx_busy) |-> $past(transmit_enable) && $past(module_enable))
      else $error("transmit started without enable");
   a_tx_event_cause: assert property (
      tx_irq_out |-> $past(tx_load) && (!$past(tx_irq_select) || tx_cnt == 3'h0))
      else $error("tx event without matching move");
   a_rx_full_event: assert property (
      rx_irq_out && rx_irq_select == RXI_FULL |-> rx_cnt == FIFO_FULL)
      else $error("full-mode rx event early");
   a_empty_read_stale: assert property (
      rd_rxd && rx_cnt == 3'h0 && !rx_push |=> rx_cnt == 3'h0 && $stable(rx_rp))
      else $error("empty read shifted the fifo");
endmodule

// ---- verification/uaf_peer.sv ----
// uaf_peer: remote serial end that sends frames and samples frames bit by bit.
// assumes callers pass the bit length in clocks and enter just after a clock edge.
`timescale 1ns/1ps
module uaf_peer (
   // clock
   input wire logic clk_in,
   // serial lines
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;
   // lsb first, start bit in bit 0; last bit is high so the line rests idle
   task automatic send(input logic [10:0] f, input int bt);
      for (int i = 0; i < 11; i++) begin
         line_out <= f[i];
         repeat (bt) @(posedge clk_in);
      end
   endtask
   // bounded wait for a start edge, then one sample in the middle of each bit
   task automatic recv(input int bt, output logic [10:0] f);
      int w;
      w = 0;
      f = 'x;
      while (line_in !== 1'b0 && w < 4000) begin
         @(posedge clk_in);
         w++;
      end
      repeat (bt / 2) @(posedge clk_in);
      for (int i = 0; i < 11; i++) begin
         f[i] = line_in;
         repeat ((i < 10) ? bt : 0) @(posedge clk_in);
      end
   endtask
endmodule

// ---- verification/tb_uaf_uart.sv ----
// tb_uaf_uart: self-checking bench for the serial transceiver and its fifos.
// assumes a 200 MHz clock and the remote end modelled by uaf_peer.
`timescale 1ns/1ps
module tb_uaf_uart;
   import uaf_pkg::*;
   logic clk_in, rst_n_in, serial_in, serial_out, oe, txi, rxi;
   uaf_bus_s bus_in;
   logic [15:0] rdata;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int txn = 0;
   int rxn = 0;
   // divisor 0 gives a tick every clock, so one bit lasts sixteen clocks
   int bt = 16;

   uaf_uart dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in), .rdata_out(rdata),
      .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_out(oe),
      .tx_irq_out(txi), .rx_irq_out(rxi));
   uaf_peer peer (.clk_in(clk_in), .line_in(serial_out), .line_out(serial_in));

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // event pulses last one cycle, so each sampled high level is one event
   always @(posedge clk_in) begin
      cycles++;
      if (txi === 1'b1) txn++;
      if (rxi === 1'b1) rxn++;
      if (cycles == 40000) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk_in);
      bus_in <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_in);
      bus_in.wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk_in);
      bus_in <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk_in);
      bus_in.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rchk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk(d & m, e);
   endtask

   function automatic logic [10:0] frame(input logic [8:0] d, input logic [1:0] pd,
      input logic bad);
      logic s;
      case (pd)
         PD_8E: s = ^d[7:0];
         PD_8O: s = ~^d[7:0];
         PD_9N: s = d[8];
         default: s = 1'b1;
      endcase
      return {1'b1, s ^ bad, d[7:0], 1'b0};
   endfunction

   task automatic txchk(input logic [8:0] d, input logic [1:0] pd);
      logic [10:0] f;
      peer.recv(bt, f);
      chk({5'h00, f}, {5'h00, frame(d, pd, 1'b0)});
   endtask

   task automatic low_in(input int n);
      for (int i = 0; i < n && serial_out !== 1'b0; i++) begin
         @(posedge clk_in);
         #1;
      end
      chk({15'h0, serial_out}, 16'h0000);
   endtask

   task automatic t_reset();
      #1;
      chk({14'h0, serial_out, oe}, 16'h0002);
      rchk(ADDR_MODE, 16'hffff, 16'h0000);
      rchk(ADDR_STAT, 16'hffff, 16'h0110);
      rchk(ADDR_BRG, 16'hffff, BRG_RST);
      rchk(3'h7, 16'hffff, 16'h0000);
      wr(ADDR_STAT, 16'h0400);
      rchk(ADDR_STAT, 16'h0400, 16'h0000);
   endtask

   task automatic t_tx();
      int n0;
      wr(ADDR_MODE, 16'h8000);
      wr(ADDR_STAT, 16'h0402);
      n0 = txn;
      wr(ADDR_TXD, 16'h00a5);
      low_in(4);
      txchk(9'h0a5, PD_8N);
      chk(16'(txn - n0), 16'h0001);
      chk({14'h0, serial_out, oe}, 16'h0003);
   endtask

   task automatic t_fmt();
      logic [8:0] d;
      for (int p = 0; p < 4; p++) begin
         wr(ADDR_MODE, 16'h8000 | 16'(p << 1));
         d = (p == 3) ? 9'h1c3 : 9'h0c3;
         wr(ADDR_TXD, {7'h00, d});
         low_in(bt);
         txchk(d, 2'(p));
      end
   endtask

   // two stop bits keep the next start out of the sampled frame
   task automatic t_fifo();
      int n0;
      wr(ADDR_MODE, 16'h8001);
      wr(ADDR_STAT, 16'h8402);
      n0 = txn;
      fork
         for (int k = 0; k < 5; k++) txchk(9'(17 * (k + 1)), PD_8N);
         begin
            wr(ADDR_TXD, 16'h0011);
            repeat (4) @(posedge clk_in);
            for (int k = 1; k < 6; k++) wr(ADDR_TXD, 16'(17 * (k + 1)));
            rchk(ADDR_STAT, 16'h0200, 16'h0200);
         end
      join
      repeat (2 * bt) @(posedge clk_in);
      rchk(ADDR_STAT, 16'h0300, 16'h0100);
      chk(16'(txn - n0), 16'h0002);
   endtask

   task automatic t_rx();
      int n0;
      logic [15:0] d;
      wr(ADDR_MODE, 16'h8000);
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_STAT, 16'h0402 | 16'(s << 6));
         n0 = rxn;
         for (int k = 0; k < 4; k++) peer.send(frame(9'(49 + 17 * k + s), PD_8N, 1'b0), bt);
         repeat (4) @(posedge clk_in);
         chk(16'(rxn - n0), (s < 2) ? 16'h0004 : 16'h0001);
         rchk(ADDR_STAT, 16'h0001, 16'h0001);
         for (int k = 0; k < 4; k++) rchk(ADDR_RXD, 16'hffff, 16'(49 + 17 * k + s));
         rd(ADDR_RXD, d);
         rchk(ADDR_STAT, 16'h0001, 16'h0000);
      end
      for (int k = 0; k < 6; k++) peer.send(frame(9'(k + 1), PD_8N, 1'b0), bt);
      repeat (4) @(posedge clk_in);
      rchk(ADDR_STAT, 16'h0003, 16'h0003);
      for (int k = 0; k < 4; k++) rchk(ADDR_RXD, 16'hffff, 16'(k + 1));
      wr(ADDR_STAT, 16'h04c0);
      rchk(ADDR_STAT, 16'h0002, 16'h0000);
      repeat (2) rd(ADDR_RXD, d);
   endtask

   task automatic t_err();
      logic [15:0] d;
      wr(ADDR_MODE, 16'h8002);
      fork
         peer.send(frame(9'h03c, PD_8E, 1'b1), bt);
         begin
            repeat (100) @(posedge clk_in);
            rchk(ADDR_STAT, 16'h0010, 16'h0000);
         end
      join
      repeat (4) @(posedge clk_in);
      rchk(ADDR_STAT, 16'h001d, 16'h0019);
      rchk(ADDR_RXD, 16'hffff, 16'h003c);
      wr(ADDR_MODE, 16'h8000);
      peer.send(frame(9'h081, PD_8N, 1'b1), bt);
      repeat (4) @(posedge clk_in);
      rchk(ADDR_STAT, 16'h000d, 16'h0005);
      rd(ADDR_RXD, d);
      rchk(ADDR_STAT, 16'h000d, 16'h0000);
   endtask

   task automatic t_brk();
      int n0;
      n0 = txn;
      wr(ADDR_STAT, 16'h0c02);
      low_in(3);
      repeat (13 * bt) @(posedge clk_in);
      #1;
      chk({15'h0, serial_out}, 16'h0000);
      wr(ADDR_STAT, 16'h0402);
      repeat (2 * bt) @(posedge clk_in);
      #1;
      chk({15'h0, serial_out}, 16'h0001);
      chk(16'(txn - n0), 16'h0000);
   endtask

   // disable between frames with a word waiting in the receive fifo and one in the transmit fifo
   task automatic t_dis();
      wr(ADDR_STAT, 16'h80c2);
      peer.send(frame(9'h044, PD_8N, 1'b0), bt);
      wr(ADDR_TXD, 16'h0077);
      repeat (50) @(posedge clk_in);
      wr(ADDR_MODE, 16'h0004);
      repeat (2) @(posedge clk_in);
      #1;
      chk({14'h0, serial_out, oe}, 16'h0002);
      rchk(ADDR_STAT, 16'hffff, 16'h81d0);
      rchk(ADDR_MODE, 16'hffff, 16'h0004);
      wr(ADDR_TXD, 16'h0011);
      wr(ADDR_MODE, 16'h8000);
      rchk(ADDR_STAT, 16'hffff, 16'h81d0);
      wr(ADDR_TXD, 16'h003e);
      repeat (40) @(posedge clk_in);
      #1;
      chk({15'h0, serial_out}, 16'h0001);
      wr(ADDR_STAT, 16'h0402);
      low_in(4);
      txchk(9'h03e, PD_8N);
   endtask

   task automatic t_baud();
      wr(ADDR_BRG, 16'h0001);
      bt = 32;
      rchk(ADDR_BRG, 16'hffff, 16'h0001);
      wr(ADDR_TXD, 16'h0096);
      low_in(4);
      txchk(9'h096, PD_8N);
      peer.send(frame(9'h069, PD_8N, 1'b0), bt);
      repeat (4) @(posedge clk_in);
      rchk(ADDR_RXD, 16'hffff, 16'h0069);
   endtask

   initial begin
      rst_n_in = 1'b0;
      bus_in = '0;
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_tx();
      t_fmt();
      t_fifo();
      t_rx();
      t_err();
      t_brk();
      t_dis();
      t_baud();
      wrap_up();
   end
endmodule
